//--- sim/edhc_core_assertions.sv
// Port checks for the emulation and protection block
`timescale 1ns/10ps
`default_nettype none
module edhc_core_assertions #(
  parameter int NI = 4,
  parameter int NO = 2,
  parameter int HPD_CYC = 400
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register writes
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // Source side
  input wire logic [NI-1:0] hpd_out,
  input wire logic [NI-1:0] hdcp_cap,
  input wire logic [NI-1:0] in_encrypted,
  // Capture and sink side
  input wire logic cap_done,
  input wire logic cap_ok,
  input wire logic [NO-1:0] sink_hdcp,
  input wire logic [NO-1:0] out_encrypt,
  input wire logic [NO-1:0] out_blank,
  input wire logic [NO-1:0] out_alert
);
  localparam int WAIT_MAX = 1000;
  logic [NI-1:0] armed;
  logic [31:0] low_cnt [NI];
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Low time of each hot-plug line, armed once it has been high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= '0;
      for (int k = 0; k < NI; k++) begin
        low_cnt[k] <= 32'h0;
      end
    end else begin
      armed <= armed | hpd_out;
      for (int k = 0; k < NI; k++) begin
        low_cnt[k] <= hpd_out[k] ? 32'h0 : low_cnt[k] + 32'h1;
      end
    end
  end
  // Per-input hot-plug and capability checks
  for (genvar k = 0; k < NI; k++) begin : g_in
    a_hpd_low_min: assert property ($rose(hpd_out[k]) && armed[k]
      |-> low_cnt[k] >= HPD_CYC - 4) else $error("hot-plug low too short");
    a_hpd_low_max: assert property (armed[k] && !hpd_out[k]
      |-> low_cnt[k] <= HPD_CYC + 4) else $error("hot-plug low too long");
    a_cfg_drops_hpd: assert property (reg_wr && reg_addr == 8'(16 + 4 * k)
      |-> ##[1:WAIT_MAX] !hpd_out[k]) else $error("no hot-plug toggle after change");
    a_cap_follows_en: assert property (reg_wr && reg_addr == 8'(16 + 4 * k)
      |=> hdcp_cap[k] == $past(reg_wdata[16])) else $error("capability not updated");
  end
  a_no_plain_enc: assert property ((sink_hdcp == '0) [*4] |-> out_encrypt == '0)
    else $error("encryption toward non-capable sink");
  a_clear_no_blank: assert property ((in_encrypted == '0) [*4] |-> out_blank == '0)
    else $error("clear stream blanked");
  a_blank_no_enc: assert property ((out_blank & out_encrypt) == '0)
    else $error("blanked output still encrypted");
  a_alert_in_blank: assert property ((out_alert & ~out_blank) == '0)
    else $error("alert without blanking");
  a_bad_cap_quiet: assert property (cap_done && !cap_ok && hpd_out == '1 && !reg_wr
    && !$past(reg_wr) |=> (hpd_out == '1) [*2]) else $error("reload on invalid capture");
  // Main scenarios reached
  c_blank: cover property (out_blank != '0);
  c_encrypt: cover property (out_encrypt != '0);
  c_good_cap: cover property (cap_done && cap_ok);
endmodule // edhc_core_assertions
bind edhc_core edhc_core_assertions #(.NI(NI), .NO(NO), .HPD_CYC(HPD_CYC)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .hpd_out(hpd_out), .hdcp_cap(hdcp_cap), .in_encrypted(in_encrypted),
  .cap_done(cap_done), .cap_ok(cap_ok), .sink_hdcp(sink_hdcp), .out_encrypt(out_encrypt),
  .out_blank(out_blank), .out_alert(out_alert)
);
`default_nettype wire

//--- sim/edhc_sink_model.sv
// Display sink model feeding captured identification bytes
`timescale 1ns/10ps
`default_nettype none
module edhc_sink_model (
  // Clock
  input wire logic mclk,
  // Commands from the bench
  input wire logic go,
  input wire logic sel,
  input wire logic ok,
  input wire logic [7:0] seed,
  // Capture bus toward the block
  output logic cap_we,
  output logic cap_sel,
  output logic [7:0] cap_addr,
  output logic [7:0] cap_data,
  output logic cap_done,
  output logic cap_ok,
  output logic busy
);
  logic [8:0] cnt = 9'h000;
  logic [7:0] sd = 8'h00;
  logic k = 1'b0;
  initial begin
    {cap_we, cap_sel, cap_addr, cap_data, cap_done, cap_ok, busy} = '0;
  end
  // Whole structure first, then its validity; idle lines keep changing
  always @(posedge mclk) begin
    cap_we <= 1'b0;
    cap_done <= 1'b0;
    cap_data <= ~cap_data;
    cap_addr <= ~cap_addr;
    cap_ok <= ~cap_ok;
    if (go && !busy) begin
      busy <= 1'b1;
      cnt <= 9'h000;
      sd <= seed;
      k <= ok;
      cap_sel <= sel;
    end else if (busy && cnt < 9'h100) begin
      cap_we <= 1'b1;
      cap_addr <= cnt[7:0];
      cap_data <= sd ^ cnt[7:0];
      cnt <= cnt + 9'h001;
    end else if (busy && cnt == 9'h100) begin
      cap_done <= 1'b1;
      cap_ok <= k;
      cnt <= cnt + 9'h001;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule // edhc_sink_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the emulation and protection block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int HPD = 400;
  logic mclk, arst_n, reg_wr, reg_rd, cap_we, cap_sel, cap_done, cap_ok, go, sel, ok, busy;
  logic [7:0] reg_addr, cap_addr, cap_data, seed, s;
  logic [31:0] reg_wdata, reg_rdata, src_addr, src_data, d;
  logic [3:0] hpd_out, hdcp_cap, src_rd, in_encrypted;
  logic [1:0] sink_hdcp, out_encrypt, out_blank, out_alert;
  logic [7:0] mem [256];
  int failures, n_tests, n;
  edhc_core #(.HPD_CYC(HPD)) dut (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hpd_out(hpd_out),
    .hdcp_cap(hdcp_cap), .src_rd(src_rd), .src_addr(src_addr), .src_data(src_data),
    .in_encrypted(in_encrypted), .cap_we(cap_we), .cap_sel(cap_sel), .cap_addr(cap_addr),
    .cap_data(cap_data), .cap_done(cap_done), .cap_ok(cap_ok), .sink_hdcp(sink_hdcp),
    .out_encrypt(out_encrypt), .out_blank(out_blank), .out_alert(out_alert)
  );
  edhc_sink_model sink (
    .mclk(mclk), .go(go), .sel(sel), .ok(ok), .seed(seed), .cap_we(cap_we),
    .cap_sel(cap_sel), .cap_addr(cap_addr), .cap_data(cap_data), .cap_done(cap_done),
    .cap_ok(cap_ok), .busy(busy)
  );
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [7:0] exp_byte(input logic [7:0] sd, input logic [7:0] a);
    return sd ^ a;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // Source-side byte read and compare; does not wait for hot-plug
  task src_chk(input int i, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    src_rd[i] <= 1'b1;
    src_addr[i*8+:8] <= a;
    @(posedge mclk);
    src_rd[i] <= 1'b0;
    @(negedge mclk);
    check(src_data[i*8+:8], e);
  endtask
  task cmp_emu(input int i, input logic [7:0] sd, input logic from_mem);
    for (int a = 0; a < 256; a++) begin
      src_chk(i, 8'(a), from_mem ? mem[a] : exp_byte(sd, 8'(a)));
    end
  endtask
  task wait_hpd(input int i);
    n = 0;
    while (hpd_out[i] !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    check(32'(n < 3000), 32'h1);
  endtask
  // One input drops hot-plug for the whole period, the others stay up
  task reload_chk(input int i, input logic [3:0] mask);
    repeat (4) @(negedge mclk);
    check(hpd_out, mask);
    wait_hpd(i);
    check(n >= HPD - 10 && n <= HPD, 1'b1);
  endtask
  task capture(input logic o, input logic [7:0] sd, input logic k);
    @(posedge mclk);
    go <= 1'b1;
    sel <= o;
    seed <= sd;
    ok <= k;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    while (busy === 1'b1) @(negedge mclk);
  endtask
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #1600000;
    failures++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {arst_n, reg_wr, reg_rd, go, sel, ok} = '0;
    {reg_addr, reg_wdata, src_rd, src_addr, in_encrypted, sink_hdcp, seed} = '0;
    failures = 0;
    n_tests = 0;
    void'($urandom(44));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) wait_hpd(i);
    check(hdcp_cap, 32'hF);
    rd(8'hFC);
    check(d, 32'h0);
    // Static emulation of a programmed slot on input 2
    wr(edhc_pkg::REG_STORE_ADDR, 32'h100);
    for (int a = 0; a < 256; a++) begin
      mem[a] = 8'($urandom);
      wr(edhc_pkg::REG_STORE_DATA, {24'h0, mem[a]});
    end
    rd(edhc_pkg::REG_STORE_ADDR);
    check(d, 32'h200);
    wr(8'h18, 32'h1_0001);
    reload_chk(2, 4'hB);
    cmp_emu(2, 8'h00, 1'b1);
    // Dynamic emulation following output 1
    s = 8'($urandom);
    @(posedge mclk);
    sink_hdcp <= 2'b10;
    capture(1'b1, s, 1'b1);
    rd(edhc_pkg::REG_STATUS);
    check({d[25:24], d[17:16], d[11:8], d[0]}, {4'hA, 4'hF, 1'b0});
    wr(8'h14, 32'h1_1100);
    reload_chk(1, 4'hD);
    cmp_emu(1, s, 1'b0);
    rd(8'h14);
    check(d, 32'h1_1100);
    s = ~s;
    capture(1'b1, s, 1'b1);
    reload_chk(1, 4'hD);
    cmp_emu(1, s, 1'b0);
    // Invalid capture leaves the emulation alone
    capture(1'b1, ~s, 1'b0);
    repeat (4) @(negedge mclk);
    check(hpd_out, 4'hF);
    src_chk(1, 8'h07, exp_byte(s, 8'h07));
    // Captured structure on input 3 with protection off
    wr(8'h1C, 32'h11);
    repeat (2) @(negedge mclk);
    check(hdcp_cap, 4'h7);
    wait_hpd(3);
    cmp_emu(3, ~s, 1'b0);
    // Every protection combination on both outputs
    for (int k = 0; k < 16; k++) begin
      wr(edhc_pkg::REG_OUT_BASE, {26'h0, k[3], k[2], 2'h0, 2'($urandom)});
      wr(8'h34, {26'h0, k[3], k[2], 2'h0, 2'($urandom)});
      in_encrypted <= {4{k[0]}};
      sink_hdcp <= {2{k[1]}};
      repeat (5) @(negedge mclk);
      check(out_encrypt, {2{k[1] & (k[0] | k[2])}});
      check(out_blank, {2{k[0] & ~k[1]}});
      check(out_alert, {2{k[0] & ~k[1] & k[3]}});
    end
    // Only input 2 encrypted, both outputs routed to it
    wr(edhc_pkg::REG_OUT_BASE, 32'h22);
    wr(8'h34, 32'h02);
    in_encrypted <= 4'h4;
    sink_hdcp <= 2'b10;
    repeat (5) @(negedge mclk);
    check(out_encrypt, 2'b10);
    check(out_blank, 2'b01);
    check(out_alert, 2'b01);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

//--- verilog/edhc_core.sv
// Per-input identification emulation, hot-plug sequencing and protection control
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Sink structures captured per output are kept in the persistent store.
// - Any store slot may be emulated; dynamic mode uses an output's capture.
// - Dynamic inputs reload when the followed output captures a valid structure.
// - Every input owns its emulation memory; one input's change leaves others alone.
// - Emulation may be changed anytime, with a source connected and powered.
// - A changed structure toggles that input's hot-plug signal for 2 seconds.
// - Each structure holds a 128-byte base block plus a 128-byte extension.
// - Encrypted content never goes to a non-capable sink; it is blanked instead.
// - Disabled protection on an input reports that input as not capable.
// - Output auto mode encrypts only when the routed content is protected.
// - Both encrypted and clear inputs are routed per destination capability.
module edhc_core #(
  parameter int NI = edhc_pkg::N_INPUTS,
  parameter int NO = edhc_pkg::N_OUTPUTS,
  parameter int NS = edhc_pkg::N_SLOTS,
  parameter int HPD_CYC = edhc_pkg::HPD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [edhc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [edhc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [edhc_pkg::DATA_W-1:0] reg_rdata,
  // Source side, per input
  output logic [NI-1:0] hpd_out,
  output logic [NI-1:0] hdcp_cap,
  input wire logic [NI-1:0] src_rd,
  input wire logic [NI*edhc_pkg::BYTE_AW-1:0] src_addr,
  output logic [NI*8-1:0] src_data,
  input wire logic [NI-1:0] in_encrypted,
  // Sink capture, from the output reader logic
  input wire logic cap_we,
  input wire logic [$clog2(NO)-1:0] cap_sel,
  input wire logic [edhc_pkg::BYTE_AW-1:0] cap_addr,
  input wire logic [7:0] cap_data,
  input wire logic cap_done,
  input wire logic cap_ok,
  // Sink side, per output
  input wire logic [NO-1:0] sink_hdcp,
  output logic [NO-1:0] out_encrypt,
  output logic [NO-1:0] out_blank,
  output logic [NO-1:0] out_alert
);

  localparam int IW = $clog2(NI);
  localparam int OW = $clog2(NO);
  localparam int SW = $clog2(NS + NO);
  localparam int STW = SW + edhc_pkg::BYTE_AW;
  localparam int TW = $clog2(HPD_CYC + 1);
  localparam int CW = edhc_pkg::BYTE_AW + 1;

  // ****************************************
  // Parameter checks
  // ****************************************
  generate
    if (NI < 2 || NI > edhc_pkg::FIELD_MAX || NO < 2 || NO > edhc_pkg::FIELD_MAX) begin : g_chk_io
      $error("edhc_core supports 2 to 8 inputs and outputs");
    end
    if (SW > edhc_pkg::EMU_DYN_BIT || HPD_CYC < edhc_pkg::HPD_MIN_CYCLES) begin : g_chk_sz
      $error("edhc_core slot count too large or hot-plug time too short");
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NI*SW-1:0] emu_slot;
    logic [NI-1:0] emu_dyn;
    logic [NI*OW-1:0] emu_follow;
    logic [NI-1:0] hdcp_en;
    logic [NO*IW-1:0] out_route;
    logic [NO-1:0] out_always;
    logic [NO-1:0] out_red;
    logic [STW-1:0] st_addr;
    logic wr_pend;
    logic [STW-1:0] wr_addr;
    logic [7:0] wr_data;
    logic [NI-1:0] req;
    logic [NO-1:0] out_valid;
    edhc_pkg::edhc_state_e fsm;
    logic [IW-1:0] cur;
    logic [SW-1:0] src_slot;
    logic [CW-1:0] cnt;
    logic cp_we;
    logic [edhc_pkg::BYTE_AW-1:0] cp_addr;
    logic [TW-1:0] timer;
    logic [NI-1:0] hpd;
    logic [edhc_pkg::DATA_W-1:0] rdata;
    logic [NI-1:0] enc_m;
    logic [NI-1:0] enc_s;
    logic [NO-1:0] snk_m;
    logic [NO-1:0] snk_s;
    logic [NO-1:0] out_enc;
    logic [NO-1:0] out_blk;
    logic [NO-1:0] out_alr;
  } edhc_st_s;

  edhc_st_s q;
  edhc_st_s next_q;

  // Store and emulation memory ports
  logic st_we;
  logic [STW-1:0] st_waddr;
  logic [7:0] st_wdata;
  logic st_re;
  logic [STW-1:0] st_raddr;
  logic [7:0] st_rdata;

  // ****************************************
  // Helpers
  // ****************************************
  // Register slot address for entry k of a bank
  function automatic logic [7:0] reg_slot(input logic [7:0] base, input int k);
    reg_slot = base + 8'(k * edhc_pkg::REG_STRIDE);
  endfunction

  // Store slot holding the capture of output o
  function automatic logic [SW-1:0] cap_slot(input logic [OW-1:0] o);
    cap_slot = SW'(NS) + SW'(o);
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [NI-1:0] new_req;
    logic [NI-1:0] clr_req;
    logic [IW-1:0] pick;
    logic [IW-1:0] r;
    logic [edhc_pkg::DATA_W-1:0] rd;
    new_req = '0;
    clr_req = '0;
    pick = '0;
    r = '0;
    rd = '0;
    next_q = q;

    // Pin synchronisers
    next_q.enc_m = in_encrypted;
    next_q.enc_s = q.enc_m;
    next_q.snk_m = sink_hdcp;
    next_q.snk_s = q.snk_m;

    // Per-input configuration writes request a reload
    for (int i = 0; i < NI; i++) begin
      if (reg_wr && reg_addr == reg_slot(edhc_pkg::REG_EMU_BASE, i)) begin
        next_q.emu_slot[i*SW +: SW] = reg_wdata[edhc_pkg::EMU_SLOT_LSB +: SW];
        next_q.emu_dyn[i] = reg_wdata[edhc_pkg::EMU_DYN_BIT];
        next_q.emu_follow[i*OW +: OW] = reg_wdata[edhc_pkg::EMU_FOLLOW_LSB +: OW];
        next_q.hdcp_en[i] = reg_wdata[edhc_pkg::EMU_HDCP_BIT];
        new_req[i] = 1'b1;
      end
    end

    // Per-output protection settings
    for (int o = 0; o < NO; o++) begin
      if (reg_wr && reg_addr == reg_slot(edhc_pkg::REG_OUT_BASE, o)) begin
        next_q.out_route[o*IW +: IW] = reg_wdata[edhc_pkg::OUT_ROUTE_LSB +: IW];
        next_q.out_always[o] = reg_wdata[edhc_pkg::OUT_ALWAYS_BIT];
        next_q.out_red[o] = reg_wdata[edhc_pkg::OUT_RED_BIT];
      end
    end

    // Capture completion marks validity and wakes followers
    if (cap_done) begin
      next_q.out_valid[cap_sel] = cap_ok;
      for (int i = 0; i < NI; i++) begin
        if (cap_ok && q.emu_dyn[i] && q.emu_follow[i*OW +: OW] == cap_sel) begin
          new_req[i] = 1'b1;
        end
      end
    end

    // Store write: capture first, software byte waits until a cycle without a capture write
    st_we = cap_we | q.wr_pend;
    st_waddr = cap_we ? {cap_slot(cap_sel), cap_addr} : q.wr_addr;
    st_wdata = cap_we ? cap_data : q.wr_data;
    if (!cap_we) begin
      next_q.wr_pend = 1'b0;
    end
    if (reg_wr && reg_addr == edhc_pkg::REG_STORE_ADDR) begin
      next_q.st_addr = reg_wdata[STW-1:0];
    end
    if (reg_wr && reg_addr == edhc_pkg::REG_STORE_DATA) begin
      next_q.wr_pend = 1'b1;
      next_q.wr_addr = q.st_addr;
      next_q.wr_data = reg_wdata[7:0];
      next_q.st_addr = q.st_addr + STW'(1);
    end

    // Copy engine read side
    st_re = (q.fsm == edhc_pkg::ST_COPY) && (q.cnt < CW'(edhc_pkg::EDID_BYTES));
    st_raddr = {q.src_slot, q.cnt[edhc_pkg::BYTE_AW-1:0]};
    next_q.cp_we = st_re;
    next_q.cp_addr = q.cnt[edhc_pkg::BYTE_AW-1:0];

    // Lowest pending input wins the engine
    for (int i = NI - 1; i >= 0; i--) begin
      if (q.req[i]) begin
        pick = IW'(i);
      end
    end

    // Reload sequence with hot-plug low throughout
    case (q.fsm)
      edhc_pkg::ST_IDLE: begin
        if (|q.req) begin
          clr_req[pick] = 1'b1;
          next_q.cur = pick;
          next_q.src_slot = q.emu_dyn[pick] ? cap_slot(q.emu_follow[pick*OW +: OW])
                                            : q.emu_slot[pick*SW +: SW];
          next_q.hpd[pick] = 1'b0;
          next_q.cnt = '0;
          next_q.timer = '0;
          next_q.fsm = edhc_pkg::ST_COPY;
        end
      end
      edhc_pkg::ST_COPY: begin
        next_q.timer = q.timer + TW'(1);
        if (st_re) begin
          next_q.cnt = q.cnt + CW'(1);
        end else if (!q.cp_we) begin
          next_q.fsm = edhc_pkg::ST_HOLD;
        end
      end
      edhc_pkg::ST_HOLD: begin
        next_q.timer = q.timer + TW'(1);
        if (q.timer >= TW'(HPD_CYC - 1)) begin
          next_q.hpd[q.cur] = 1'b1;
          next_q.fsm = edhc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_q.fsm = edhc_pkg::ST_IDLE;
      end
    endcase

    // New requests win over the clear
    next_q.req = (q.req & ~clr_req) | new_req;

    // Output protection decisions
    for (int o = 0; o < NO; o++) begin
      r = q.out_route[o*IW +: IW];
      next_q.out_enc[o] = q.snk_s[o] & (q.enc_s[r] | q.out_always[o]);
      next_q.out_blk[o] = q.enc_s[r] & ~q.snk_s[o];
      next_q.out_alr[o] = q.enc_s[r] & ~q.snk_s[o] & q.out_red[o];
    end

    // Register read, data valid the following cycle only
    if (reg_rd) begin
      if (reg_addr == edhc_pkg::REG_STATUS) begin
        rd[edhc_pkg::STAT_BUSY_BIT] = (q.fsm != edhc_pkg::ST_IDLE);
        rd[edhc_pkg::STAT_HPD_LSB +: NI] = q.hpd;
        rd[edhc_pkg::STAT_VALID_LSB +: NO] = q.out_valid;
        rd[edhc_pkg::STAT_SINK_LSB +: NO] = q.snk_s;
      end
      if (reg_addr == edhc_pkg::REG_STORE_ADDR) begin
        rd[STW-1:0] = q.st_addr;
      end
      for (int i = 0; i < NI; i++) begin
        if (reg_addr == reg_slot(edhc_pkg::REG_EMU_BASE, i)) begin
          rd[edhc_pkg::EMU_SLOT_LSB +: SW] = q.emu_slot[i*SW +: SW];
          rd[edhc_pkg::EMU_DYN_BIT] = q.emu_dyn[i];
          rd[edhc_pkg::EMU_FOLLOW_LSB +: OW] = q.emu_follow[i*OW +: OW];
          rd[edhc_pkg::EMU_HDCP_BIT] = q.hdcp_en[i];
        end
      end
      for (int o = 0; o < NO; o++) begin
        if (reg_addr == reg_slot(edhc_pkg::REG_OUT_BASE, o)) begin
          rd[edhc_pkg::OUT_ROUTE_LSB +: IW] = q.out_route[o*IW +: IW];
          rd[edhc_pkg::OUT_ALWAYS_BIT] = q.out_always[o];
          rd[edhc_pkg::OUT_RED_BIT] = q.out_red[o];
        end
      end
    end
    next_q.rdata = rd;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.req <= '1; // Load every input once after reset
      q.hdcp_en <= '1;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Memories
  // ****************************************
  // Structure store: user slots then one capture slot per output
  edhc_mem #(.AW(STW), .DW(8)) u_store (
    .clk(mclk),
    .we(st_we),
    .waddr(st_waddr),
    .wdata(st_wdata),
    .re(st_re),
    .raddr(st_raddr),
    .rdata(st_rdata)
  );

  // One emulation memory per input, read by its source
  generate
    for (genvar i = 0; i < NI; i++) begin : g_emu
      edhc_mem #(.AW(edhc_pkg::BYTE_AW), .DW(8)) u_emu (
        .clk(mclk),
        .we(q.cp_we && q.cur == IW'(i)),
        .waddr(q.cp_addr),
        .wdata(st_rdata),
        .re(src_rd[i]),
        .raddr(src_addr[i*edhc_pkg::BYTE_AW +: edhc_pkg::BYTE_AW]),
        .rdata(src_data[i*8 +: 8])
      );
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = q.rdata;
  assign hpd_out = q.hpd;
  assign hdcp_cap = q.hdcp_en;
  assign out_encrypt = q.out_enc;
  assign out_blank = q.out_blk;
  assign out_alert = q.out_alr;

endmodule // edhc_core
`default_nettype wire

//--- verilog/edhc_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module edhc_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  generate
    if (AW < 1 || DW < 1) begin : g_chk
      $error("edhc_mem needs positive widths");
    end
  endgenerate

  // Write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule // edhc_mem
`default_nettype wire

//--- verilog/edhc_pkg.sv
// Shared constants and types for the identification emulation and protection control block
package edhc_pkg;

  // ****************************************
  // Register bus geometry
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_STORE_ADDR = 8'h04;
  localparam logic [7:0] REG_STORE_DATA = 8'h08;
  localparam logic [7:0] REG_EMU_BASE = 8'h10;
  localparam logic [7:0] REG_OUT_BASE = 8'h30;
  localparam int REG_STRIDE = 4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EMU_SLOT_LSB = 0;
  localparam int EMU_DYN_BIT = 8;
  localparam int EMU_FOLLOW_LSB = 12;
  localparam int EMU_HDCP_BIT = 16;
  localparam int OUT_ROUTE_LSB = 0;
  localparam int OUT_ALWAYS_BIT = 4;
  localparam int OUT_RED_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HPD_LSB = 8;
  localparam int STAT_VALID_LSB = 16;
  localparam int STAT_SINK_LSB = 24;
  localparam int FIELD_MAX = 8;

  // ****************************************
  // Structure sizes
  // ****************************************
  localparam int BLOCK_BYTES = 128;
  localparam int EDID_BYTES = 2 * BLOCK_BYTES;
  localparam int BYTE_AW = 8;
  localparam int N_SLOTS = 16;
  localparam int N_INPUTS = 4;
  localparam int N_OUTPUTS = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ = 25000;
  localparam int HPD_TOGGLE_MS = 2000;
  localparam int HPD_CYCLES = HPD_TOGGLE_MS * CLK_KHZ;
  localparam int HPD_MIN_CYCLES = EDID_BYTES + 8;

  // ****************************************
  // Copy engine states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COPY = 2'b01,
    ST_HOLD = 2'b11
  } edhc_state_e;

endpackage
